// ==== verilog/conv_ctrl_map.svh ====
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH
// data word width and pipeline depth in conversion clocks
`define CONV_DATA_W        14
`define CONV_PIPE_DEPTH    13
// least hold of reset and calibrate, in clocks
`define CONV_MIN_PULSE     2
// self-calibration length in clocks
`define CONV_CAL_CYCLES    272800
// wake-up time after power-down, in clocks (plain default)
`define CONV_WAKE_CYCLES   16
// reference settling time in ms and its clock count at 125 MHz
`define CONV_SETTLE_MS     100
`define CONV_CLK_MHZ       125
`define CONV_SETTLE_CYCLES (`CONV_SETTLE_MS * 1000 * `CONV_CLK_MHZ)
// extreme and zero two's-complement codes
`define CONV_CODE_MIN      14'h2000
`define CONV_CODE_MAX      14'h1FFF
`define CONV_CODE_ZERO     14'h0000
`endif

// ==== verilog/conv_ctrl_pkg.sv ====
`default_nettype none
package conv_ctrl_pkg;
   typedef enum logic [2:0] {
      DEV_OFF,
      DEV_WAKE,
      DEV_RESET,
      DEV_CAL,
      DEV_RUN
   } dev_state_t;
   typedef enum logic [2:0] {
      HOST_SETTLE,
      HOST_RESET,
      HOST_CAL,
      HOST_CAL_WAIT,
      HOST_READY,
      HOST_DOWN
   } host_state_t;
endpackage : conv_ctrl_pkg
`default_nettype wire

// ==== verilog/conv_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface conv_link_if;
   logic        reset;
   logic        calibrate;
   logic        read_n;
   logic        power_down_n;
   logic        eoc_n;
   logic [13:0] data_out;
   logic        data_oe_n;
   logic [13:0] data_bus;
   // tri-state resolution of the data pins, x-free when released
   always_comb begin
      data_bus = data_oe_n ? 14'h0000 : data_out;
   end
   modport device (
      input  reset,
      input  calibrate,
      input  read_n,
      input  power_down_n,
      output eoc_n,
      output data_out,
      output data_oe_n
   );
   modport host (
      output reset,
      output calibrate,
      output read_n,
      output power_down_n,
      input  eoc_n,
      input  data_bus
   );
endinterface : conv_link_if
`default_nettype wire

// ==== verilog/conv_device.sv ====
// Summary of operation
// [RULE1] sign bit low when positive input larger
// [RULE2] zero differential input gives code zero
// [RULE3] mux selection changes on rising clock only
// [RULE4] host keeps clock continuous within range
// [RULE5] clock drives state; stopping corrupts pipeline
// [RULE6] host holds reset two clocks after power-up
// [RULE7] calibrate held two clocks starts calibration
// [RULE8] host resets before every calibration
// [RULE9] host recalibrates after power-down or drift
// [RULE10] host calibrates at conversion clock rate
// [RULE11] calibration lasts 272800 clocks
// [RULE12] words invalid during reset/calibrate plus 13
// [RULE13] host waits for reference settling first
// [RULE14] data drivers enabled while read low
// [RULE15] power-down low holds low-power, corrupts pipeline
// [RULE16] resume within wake-up time after power-down
// [RULE17] host resets and calibrates after power-down
// [RULE18] one word per clock, 13 clocks late
// [RULE19] end-of-conversion low while data valid
// [RULE20] output words are two's complement
// [RULE21] out-of-range inputs clamp to extreme codes
// [RULE22] host counts calibration plus flush cycles
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.svh"
module conv_device (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   input  wire logic [15:0] sample_i,
   conv_link_if.device      link,
   output logic             calibrating_o,
   output logic             powered_down_o
);
   // sample_i: signed differential input in a wider range than the output
   localparam int DW    = `CONV_DATA_W;
   localparam int DEPTH = `CONV_PIPE_DEPTH;
   localparam logic [18:0] CAL_N  = 19'(`CONV_CAL_CYCLES);
   localparam logic [18:0] WAKE_N = 19'(`CONV_WAKE_CYCLES);
   localparam logic [3:0]  FLUSH  = 4'(`CONV_PIPE_DEPTH);

   conv_ctrl_pkg::dev_state_t state_q;
   logic [18:0]               cnt_q;
   logic [3:0]                flush_q;
   logic [DW-1:0]             pipe_q [DEPTH];
   logic                      rst_q;
   logic                      cal_q;

   // output meaningful only in run mode with both control pins released
   function automatic logic out_defined(input conv_ctrl_pkg::dev_state_t st,
                                        input logic                      rst,
                                        input logic                      cal);
      out_defined = (st == conv_ctrl_pkg::DEV_RUN) && !rst && !cal;
   endfunction : out_defined

   // terminal test of the shared wake-up and calibration counter
   function automatic logic count_done(input logic [18:0] cnt,
                                       input logic [18:0] len);
      count_done = (cnt == len - 19'h00001);
   endfunction : count_done

   // saturate to the two extreme codes, two's complement kept as is
   function automatic logic [DW-1:0] quantise(input logic [15:0] s);
      if ($signed(s) < $signed(16'hE000)) begin
         quantise = `CONV_CODE_MIN; // RULE21
      end else if ($signed(s) > $signed(16'h1FFF)) begin
         quantise = `CONV_CODE_MAX; // RULE21
      end else begin
         // sign bit high for negative input, zero maps to zero
         quantise = s[DW-1:0]; // RULE1 RULE2 RULE20
      end
   endfunction : quantise

   // pins are synchronous; previous levels give two-clock qualification
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_q <= 1'b0;
      end else if (ce_i) begin
         rst_q <= link.reset;
      end
   end

   // a one-clock glitch on calibrate never starts a calibration
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cal_q <= 1'b0;
      end else if (ce_i) begin
         cal_q <= link.calibrate;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q <= conv_ctrl_pkg::DEV_RUN;
         cnt_q   <= 19'h00000;
      end else if (ce_i) begin // RULE5
         // power-down wins over every state, calibration included
         if (!link.power_down_n) begin
            state_q <= conv_ctrl_pkg::DEV_OFF; // RULE15
            cnt_q   <= 19'h00000;
         end else begin
            case (state_q)
               // pipeline is stale after waking; host must recalibrate
               conv_ctrl_pkg::DEV_OFF: begin
                  state_q <= conv_ctrl_pkg::DEV_WAKE;
                  cnt_q   <= 19'h00000;
               end
               conv_ctrl_pkg::DEV_WAKE: begin
                  // reset and calibrate are refused until wake-up ends
                  if (count_done(cnt_q, WAKE_N)) begin
                     state_q <= conv_ctrl_pkg::DEV_RUN; // RULE16
                  end else begin
                     cnt_q <= cnt_q + 19'h00001;
                  end
               end
               conv_ctrl_pkg::DEV_CAL: begin
                  // reset aborts a running calibration at once
                  if (link.reset) begin
                     state_q <= conv_ctrl_pkg::DEV_RESET;
                  end else if (count_done(cnt_q, CAL_N)) begin
                     state_q <= conv_ctrl_pkg::DEV_RUN; // RULE11
                  end else begin
                     cnt_q <= cnt_q + 19'h00001;
                  end
               end
               // run and reset states share the pin decoding
               default: begin
                  if (link.reset && rst_q) begin
                     state_q <= conv_ctrl_pkg::DEV_RESET;
                  end else if (state_q == conv_ctrl_pkg::DEV_RESET && !link.reset) begin
                     state_q <= conv_ctrl_pkg::DEV_RUN;
                  end else if (link.calibrate && cal_q) begin
                     state_q <= conv_ctrl_pkg::DEV_CAL; // RULE7
                     cnt_q   <= 19'h00000;
                  end
               end
            endcase
         end
      end
   end

   // one stage per clock; word leaves DEPTH clocks after capture
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            pipe_q[i] <= `CONV_CODE_ZERO;
         end
      end else if (ce_i) begin
         pipe_q[0] <= quantise(sample_i); // RULE18
         for (int i = 1; i < DEPTH; i++) begin
            pipe_q[i] <= pipe_q[i-1];
         end
      end
   end

   // validity: flush count restarts whenever output is undefined
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flush_q <= FLUSH;
      end else if (ce_i) begin
         if (!out_defined(state_q, link.reset, link.calibrate)) begin
            flush_q <= FLUSH; // RULE12
         end else if (flush_q != 4'h0) begin
            flush_q <= flush_q - 4'h1;
         end
      end
   end

   // output register adds one clock beyond the last pipeline stage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link.data_out <= `CONV_CODE_ZERO;
      end else if (ce_i) begin
         link.data_out <= pipe_q[DEPTH-1]; // RULE18
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link.data_oe_n <= 1'b1;
      end else if (ce_i) begin
         link.data_oe_n <= link.read_n; // RULE14
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link.eoc_n <= 1'b1;
      end else if (ce_i) begin
         link.eoc_n <= !(flush_q == 4'h0
                         && out_defined(state_q, link.reset, link.calibrate)); // RULE19 RULE12
      end
   end

   // status flags trail the state by one clock
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         calibrating_o  <= 1'b0;
         powered_down_o <= 1'b0;
      end else if (ce_i) begin
         calibrating_o  <= (state_q == conv_ctrl_pkg::DEV_CAL);
         powered_down_o <= (state_q == conv_ctrl_pkg::DEV_OFF);
      end
   end
endmodule : conv_device
`default_nettype wire

// ==== verilog/conv_host.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.svh"
module conv_host #(
   parameter int SETTLE_CYCLES = `CONV_SETTLE_CYCLES,
   parameter int CAL_CYCLES    = `CONV_CAL_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   input  wire logic        sleep_i,
   input  wire logic        recal_i,
   input  wire logic        read_en_i,
   conv_link_if.host        link,
   output logic             ready_o,
   output logic             word_valid_o,
   output logic [13:0]      word_o
);
   logic [31:0]                wait_q;
   logic [1:0]                 pulse_q;
   logic                       drive_n_q;
   conv_ctrl_pkg::host_state_t state_q;
   localparam logic [31:0] SETTLE_N = 32'(SETTLE_CYCLES);
   localparam logic [31:0] CALW_N   = 32'(CAL_CYCLES + `CONV_PIPE_DEPTH);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q           <= conv_ctrl_pkg::HOST_SETTLE;
         wait_q            <= 32'h00000000;
         pulse_q           <= 2'h0;
         link.reset        <= 1'b0;
         link.calibrate    <= 1'b0;
         link.power_down_n <= 1'b1;
         ready_o           <= 1'b0;
      end else if (ce_i) begin // RULE4 RULE10
         case (state_q)
            conv_ctrl_pkg::HOST_SETTLE: begin
               link.power_down_n <= 1'b1;
               if (wait_q >= SETTLE_N - 32'h1) begin
                  state_q    <= conv_ctrl_pkg::HOST_RESET; // RULE13
                  link.reset <= 1'b1;
                  pulse_q    <= 2'h0;
               end else begin
                  wait_q <= wait_q + 32'h1;
               end
            end
            conv_ctrl_pkg::HOST_RESET: begin
               // hold high one extra clock beyond the least two
               if (pulse_q == 2'(`CONV_MIN_PULSE)) begin
                  link.reset     <= 1'b0;
                  link.calibrate <= 1'b1; // RULE8
                  pulse_q        <= 2'h0;
                  state_q        <= conv_ctrl_pkg::HOST_CAL;
               end else begin
                  pulse_q <= pulse_q + 2'h1; // RULE6
               end
            end
            conv_ctrl_pkg::HOST_CAL: begin
               if (pulse_q == 2'(`CONV_MIN_PULSE)) begin
                  link.calibrate <= 1'b0; // RULE7
                  wait_q         <= 32'h00000000;
                  state_q        <= conv_ctrl_pkg::HOST_CAL_WAIT;
               end else begin
                  pulse_q <= pulse_q + 2'h1;
               end
            end
            conv_ctrl_pkg::HOST_CAL_WAIT: begin
               if (wait_q >= CALW_N) begin
                  state_q <= conv_ctrl_pkg::HOST_READY; // RULE22
                  ready_o <= 1'b1;
               end else begin
                  wait_q <= wait_q + 32'h1;
               end
            end
            conv_ctrl_pkg::HOST_READY: begin
               if (sleep_i) begin
                  link.power_down_n <= 1'b0;
                  ready_o           <= 1'b0;
                  state_q           <= conv_ctrl_pkg::HOST_DOWN;
               end else if (recal_i) begin
                  ready_o    <= 1'b0; // RULE9
                  link.reset <= 1'b1;
                  pulse_q    <= 2'h0;
                  state_q    <= conv_ctrl_pkg::HOST_RESET;
               end
            end
            default: begin
               if (!sleep_i) begin
                  link.power_down_n <= 1'b1;
                  wait_q            <= 32'h00000000;
                  state_q           <= conv_ctrl_pkg::HOST_SETTLE; // RULE17
               end
            end
         endcase
         // power-down is honoured in every state, not only once calibrated
         if (sleep_i && state_q != conv_ctrl_pkg::HOST_DOWN) begin
            link.power_down_n <= 1'b0;
            link.reset        <= 1'b0;
            link.calibrate    <= 1'b0;
            ready_o           <= 1'b0;
            state_q           <= conv_ctrl_pkg::HOST_DOWN;
         end
      end
   end

   // capture on the rising edge, only words flagged valid and after calibration
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link.read_n  <= 1'b1;
         drive_n_q    <= 1'b1;
         word_valid_o <= 1'b0;
         word_o       <= 14'h0000;
      end else if (ce_i) begin
         link.read_n  <= !read_en_i;
         // drivers follow read_n a clock late; a word counts only when driven
         drive_n_q    <= link.read_n;
         word_valid_o <= ready_o && !link.eoc_n && !drive_n_q; // RULE12
         if (ready_o && !link.eoc_n && !drive_n_q) begin
            word_o <= link.data_bus;
         end
      end
   end
endmodule : conv_host
`default_nettype wire

// ==== test/conv_link_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module conv_link_checker (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic reset,
   input wire logic calibrate,
   input wire logic read_n,
   input wire logic power_down_n,
   input wire logic eoc_n,
   input wire logic data_oe_n
);
   localparam int WAKE_MAX = 1000;
   logic seen_q;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // remembers a reset since the last calibration pulse
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i)
         seen_q <= 1'b0;
      else if (reset)
         seen_q <= 1'b1;
      else if (calibrate)
         seen_q <= 1'b0;
   end
   property p_oe_follows_read;
      1'b1 |=> data_oe_n == $past(read_n);
   endproperty
   a_oe_follows_read: assert property (p_oe_follows_read)
      else $error("drive enable not one clock behind read");
   property p_flush_after_reset;
      $fell(reset) |-> eoc_n [*8] ##1 eoc_n [*5];
   endproperty
   a_flush_after_reset: assert property (p_flush_after_reset)
      else $error("valid flag within 13 clocks of reset");
   property p_flush_after_cal;
      $fell(calibrate) |-> eoc_n [*8] ##1 eoc_n [*5];
   endproperty
   a_flush_after_cal: assert property (p_flush_after_cal)
      else $error("valid flag within 13 clocks of calibrate");
   property p_down_invalid;
      !power_down_n [*4] |-> eoc_n;
   endproperty
   a_down_invalid: assert property (p_down_invalid)
      else $error("valid flag while powered down");
   property p_reset_pulse;
      $rose(reset) |-> reset [*2];
   endproperty
   a_reset_pulse: assert property (p_reset_pulse)
      else $error("reset pulse shorter than two clocks");
   property p_cal_pulse;
      $rose(calibrate) |-> calibrate [*2];
   endproperty
   a_cal_pulse: assert property (p_cal_pulse)
      else $error("calibrate pulse shorter than two clocks");
   property p_reset_first;
      $rose(calibrate) |-> seen_q;
   endproperty
   a_reset_first: assert property (p_reset_first)
      else $error("calibrate without reset before it");
   property p_wake_reset;
      $rose(power_down_n) |-> ##[1:WAKE_MAX] reset;
   endproperty
   a_wake_reset: assert property (p_wake_reset)
      else $error("no reset after leaving power-down");
endmodule : conv_link_checker
`default_nettype wire

// ==== test/adc_reset_cal_powerdown_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.svh"
module adc_reset_cal_powerdown_control_tb;
   logic        clk_i   = 1'b0;
   logic        rstn_i  = 1'b0;
   logic        ce      = 1'b1;
   logic [15:0] sample  = 16'h0000;
   logic        sleep   = 1'b0;
   logic        read_en = 1'b1;
   logic        recal   = 1'b0;
   logic        wvalid;
   logic [13:0] word;
   logic        ready;
   logic        cal;
   logic        down;
   int          fails   = 0;
   int          checks  = 0;
   conv_link_if link ();
   conv_device u_conv_device (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .sample_i(sample),
      .link(link.device), .calibrating_o(cal), .powered_down_o(down));
   conv_host #(.SETTLE_CYCLES(400)) u_conv_host (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
      .sleep_i(sleep), .recal_i(recal), .read_en_i(read_en), .link(link.host),
      .ready_o(ready), .word_valid_o(wvalid), .word_o(word));
   conv_link_checker u_conv_link_checker (.clk_i(clk_i), .rstn_i(rstn_i), .reset(link.reset),
      .calibrate(link.calibrate), .read_n(link.read_n), .power_down_n(link.power_down_n),
      .eoc_n(link.eoc_n), .data_oe_n(link.data_oe_n));
   always #4 clk_i = ~clk_i;
   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   // data path is exercised in the settle window, before the host resets
   task automatic t_codes();
      logic [15:0] in_v [6] = '{16'h0000, 16'h0005, 16'hFFFB, 16'h2000, 16'hDFFF, 16'hE001};
      logic [13:0] ex_v [6] = '{14'h0000, 14'h0005, 14'h3FFB, 14'h1FFF, 14'h2000, 14'h2001};
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         sample <= in_v[i];
         cyc(16);
         chk("data", ex_v[i], link.data_bus);
         chk("sign", 14'(ex_v[i][13]), 14'(link.data_bus[13]));
         chk("eoc_n", 14'h0000, 14'(link.eoc_n));
         chk("no early word", 14'h0000, 14'(wvalid));
      end
   endtask : t_codes
   task automatic t_latency();
      int n;
      n = 0;
      @(posedge clk_i);
      sample <= 16'h0123;
      @(posedge clk_i);
      sample <= 16'h0000;
      while (n < 30 && link.data_bus !== 14'h0123) begin
         cyc(1);
         n++;
      end
      chk("latency", 14'h000D, 14'(n));
   endtask : t_latency
   task automatic t_freeze();
      @(posedge clk_i);
      ce     <= 1'b0;
      sample <= 16'h0777;
      cyc(20);
      chk("frozen data", 14'h0000, link.data_bus);
      @(posedge clk_i);
      ce <= 1'b1;
      cyc(16);
      chk("resumed data", 14'h0777, link.data_bus);
      @(posedge clk_i);
      sample <= 16'h0000;
   endtask : t_freeze
   task automatic t_read_off();
      @(posedge clk_i);
      read_en <= 1'b0;
      cyc(4);
      chk("oe_n off", 14'h0001, 14'(link.data_oe_n));
      chk("bus off", 14'h0000, link.data_bus);
      @(posedge clk_i);
      read_en <= 1'b1;
      cyc(4);
      chk("oe_n on", 14'h0000, 14'(link.data_oe_n));
   endtask : t_read_off
   // full 272800-clock calibration is not waited out, to keep the run short
   task automatic t_calibrate();
      int n;
      int hits;
      n = 0;
      hits = 0;
      while (n < 800 && cal !== 1'b1) begin
         cyc(1);
         n++;
      end
      chk("cal start", 14'h0001, 14'(cal));
      @(posedge clk_i);
      recal <= 1'b1;
      @(posedge clk_i);
      recal <= 1'b0;
      repeat (100) begin
         cyc(1);
         if (wvalid !== 1'b0) hits++;
      end
      chk("cal eoc_n", 14'h0001, 14'(link.eoc_n));
      chk("cal busy", 14'h0001, 14'(cal));
      chk("captures", 14'h0000, 14'(hits));
      chk("word", 14'h0000, word);
      chk("not ready", 14'h0000, 14'(ready));
   endtask : t_calibrate
   task automatic t_power_down();
      int n;
      @(posedge clk_i);
      sleep <= 1'b1;
      cyc(8);
      chk("down", 14'h0001, 14'(down));
      chk("cal aborted", 14'h0000, 14'(cal));
      @(posedge clk_i);
      sleep <= 1'b0;
      n = 0;
      while (n < 200 && down !== 1'b0) begin
         cyc(1);
         n++;
      end
      chk("wake in time", 14'h0001, 14'(n <= 20));
      n = 0;
      while (n < 200 && link.eoc_n !== 1'b0) begin
         cyc(1);
         n++;
      end
      chk("resumed", 14'h0001, 14'(n <= `CONV_WAKE_CYCLES + `CONV_PIPE_DEPTH + 2));
      n = 0;
      while (n < 1000 && cal !== 1'b1) begin
         cyc(1);
         n++;
      end
      chk("recal", 14'h0001, 14'(cal));
   endtask : t_power_down
   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_codes();
      t_latency();
      t_read_off();
      t_freeze();
      t_calibrate();
      t_power_down();
      conclude();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      conclude();
   end
endmodule : adc_reset_cal_powerdown_control_tb
`default_nettype wire
